/* logic/cbgcs_pkg.sv */
/*
 * constants, field layouts and carrier types for the general control and
 * status configuration registers of the card bridge.
 * assumes the surrounding config-space decoder presents byte addresses and
 * byte enables in the pci clock domain.
 */
// Operation
// [R1] write-protect bit locks identification registers, reset 1
// [R2] parity report bit gates cardbus parity serr
// [R3] central dma needs bit and terminal configuration
// [R4] voltage select: 0 means 3.3 V, 1 means 5 V
// [R5] clock keep bit blocks both clock stops
// [R6] mux 0: ring output and pme share, ring wins
// [R7] mux 1: only pme on shared terminal
// [R8] status bits 7-3 read zero
// [R9] control bits 7-4 and 2 read zero
// [R10] eeprom present latched from clock line in reset
// [R11] eeprom data error sets status bit
// [R12] writing one clears data error bit
// [R13] busy bit follows eeprom loader activity
// [R14] firewire off bit disables that function
// [R15] arbitration field selects priority, 11 is round robin
// [R16] reserved writes ignored, control resets zero
package cbgcs_pkg;

	// ----------------------------------------------------------------
	// config space layout
	// ----------------------------------------------------------------
	localparam logic [7:0] SYSCTL_OFFSET  = 8'h80;  // dword holding system control low byte
	localparam logic [7:0] STATUS_OFFSET  = 8'h85;
	localparam logic [7:0] CONTROL_OFFSET = 8'h86;

	// system control low bits
	localparam int SC_WP_BIT     = 5;
	localparam int SC_PAR_BIT    = 4;
	localparam int SC_DMA_BIT    = 3;
	localparam int SC_VOLT_BIT   = 2;
	localparam int SC_KEEP_BIT   = 1;
	localparam int SC_MUX_BIT    = 0;
	localparam logic [5:0] SC_RESET    = 6'h20;
	localparam logic [5:0] SC_WR_MASK  = 6'h3f;

	// general status bits
	localparam int ST_PRESENT_BIT = 2;
	localparam int ST_ERROR_BIT   = 1;
	localparam int ST_BUSY_BIT    = 0;

	// general control bits
	localparam int GC_FW_OFF_BIT  = 3;
	localparam int GC_ARB_LSB     = 0;
	localparam logic [7:0] GC_WR_MASK = 8'h0b;
	localparam logic [7:0] GC_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CBGCS_ARB_FIREWIRE = 2'h0,
		CBGCS_ARB_CARDBUS  = 2'h1,
		CBGCS_ARB_FAIR     = 2'h2,
		CBGCS_ARB_RSVD     = 2'h3
	} cbgcs_arb_t;

	typedef enum logic [2:0] {
		CBGCS_PIN_IDLE = 3'b001,
		CBGCS_PIN_RING = 3'b010,
		CBGCS_PIN_PME  = 3'b100
	} cbgcs_pin_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cbgcs_cfg_req_t;

	typedef struct packed {
		logic       ring_req;
		logic       pme_req;
	} cbgcs_wake_t;

	typedef struct packed {
		logic       fw_prio;
		logic       cb_prio;
		logic       fair;
	} cbgcs_arb_sel_t;

endpackage

/* logic/cbgcs_regs.sv */
/*
 * general control and status register bank of the card bridge: system
 * control low bits, general status and general control, all in config
 * space and clocked by the pci clock.
 * assumes the config decoder presents byte addresses with byte enables and
 * that the eeprom loader and parity checker run on the same clock.
 */
`timescale 1ns/1ps
module cbgcs_regs (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire cbgcs_pkg::cbgcs_cfg_req_t cfg_req,
	output logic [31:0]                   cfg_rdata,
	output logic                          cfg_hit,
	input  wire logic                     scl_pin,
	input  wire logic                     eeprom_error_pulse,
	input  wire logic                     eeprom_loading,
	input  wire logic                     cardbus_parity_error,
	input  wire logic                     terminals_central_dma,
	input  wire logic                     legacy_mode,
	input  wire logic                     cb_stop_request,
	input  wire logic                     pci_stop_request,
	input  wire cbgcs_pkg::cbgcs_wake_t    wake,
	output logic                          id_write_enable,
	output logic                          serr_parity_pulse,
	output logic                          central_dma_active,
	output logic                          card_5v_select,
	output logic                          card_3v_select,
	output logic                          cb_stop_grant,
	output logic                          pci_stop_grant,
	output logic                          ring_pme_pin_n,
	output logic                          firewire_function_off,
	output cbgcs_pkg::cbgcs_arb_sel_t      arb_sel
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic dword_hit(input logic [7:0] a, input logic [7:0] off);
		dword_hit = (a[7:2] == off[7:2]);
	endfunction

	function automatic logic lane_en(input logic [3:0] be, input logic [7:0] off);
		lane_en = be[off[1:0]];
	endfunction

	logic [5:0] sc_q;
	logic [5:0] sc_d;
	logic [7:0] gc_q;
	logic [7:0] gc_d;
	logic       err_q;
	logic       err_d;
	logic       present_q;
	logic       scl_sync;
	logic       rst_seen_q;
	logic       serr_q;
	logic       pin_q;
	cbgcs_pkg::cbgcs_pin_t pin_state;

	wire sc_wr  = cfg_req.wr && dword_hit(cfg_req.addr, cbgcs_pkg::SYSCTL_OFFSET)
		&& lane_en(cfg_req.be, cbgcs_pkg::SYSCTL_OFFSET);
	wire st_wr  = cfg_req.wr && dword_hit(cfg_req.addr, cbgcs_pkg::STATUS_OFFSET)
		&& lane_en(cfg_req.be, cbgcs_pkg::STATUS_OFFSET);
	wire gc_wr  = cfg_req.wr && dword_hit(cfg_req.addr, cbgcs_pkg::CONTROL_OFFSET)
		&& lane_en(cfg_req.be, cbgcs_pkg::CONTROL_OFFSET);
	wire sc_hit = dword_hit(cfg_req.addr, cbgcs_pkg::SYSCTL_OFFSET);
	wire gs_hit = dword_hit(cfg_req.addr, cbgcs_pkg::STATUS_OFFSET);

	wire [7:0] sc_wbyte = cfg_req.wdata[8*cbgcs_pkg::SYSCTL_OFFSET[1:0] +: 8];
	wire [7:0] st_wbyte = cfg_req.wdata[8*cbgcs_pkg::STATUS_OFFSET[1:0] +: 8];
	wire [7:0] gc_wbyte = cfg_req.wdata[8*cbgcs_pkg::CONTROL_OFFSET[1:0] +: 8];

	// ----------------------------------------------------------------
	// system control low bits
	// ----------------------------------------------------------------
	assign sc_d = sc_wr ? (sc_wbyte[5:0] & cbgcs_pkg::SC_WR_MASK) : sc_q;

	// ----------------------------------------------------------------
	// general control
	// ----------------------------------------------------------------
	assign gc_d = gc_wr ? (gc_wbyte & cbgcs_pkg::GC_WR_MASK) : gc_q; // R16 R9

	// ----------------------------------------------------------------
	// general status
	// ----------------------------------------------------------------
	// set wins over a same-cycle write-one clear so no error is lost
	wire err_clear = st_wr && st_wbyte[cbgcs_pkg::ST_ERROR_BIT]; // R12
	assign err_d = eeprom_error_pulse ? 1'b1 : (err_clear ? 1'b0 : err_q); // R11 R12

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_q  <= cbgcs_pkg::SC_RESET; // R1
			gc_q  <= cbgcs_pkg::GC_RESET; // R16
			err_q <= 1'b0;
		end else begin
			sc_q  <= sc_d;
			gc_q  <= gc_d;
			err_q <= err_d;
		end
	end

	// the scl level is captured by clock while reset is held, then frozen
	cbgcs_sync3 u_scl_sync (
		.clk   (clk),
		.rst_n (1'b1),
		.din   (scl_pin),
		.dout  (scl_sync)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			present_q  <= scl_sync; // R10
			rst_seen_q <= 1'b1;
		end else if (!rst_seen_q) begin
			present_q  <= 1'b0;
			rst_seen_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	wire [7:0] st_byte = {5'h0_0, present_q, err_q, eeprom_loading}; // R8 R13
	wire [7:0] gc_byte = gc_q & cbgcs_pkg::GC_WR_MASK; // R9
	// status and control return on the same lanes that their writes use;
	// lanes 0 and 3 of that dword belong to other registers and read zero here

	assign cfg_hit = cfg_req.rd && (sc_hit || gs_hit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_req.rd && sc_hit) begin
			cfg_rdata <= {26'h000_0000, sc_q};
		end else if (cfg_req.rd && gs_hit) begin
			cfg_rdata <= {8'h00, gc_byte, st_byte, 8'h00};
		end else if (cfg_req.rd) begin
			cfg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// effects of the control bits
	// ----------------------------------------------------------------
	assign id_write_enable    = !sc_q[cbgcs_pkg::SC_WP_BIT]; // R1
	assign central_dma_active = sc_q[cbgcs_pkg::SC_DMA_BIT] && terminals_central_dma; // R3
	// voltage request only meaningful in legacy compatibility mode
	assign card_5v_select     = legacy_mode && sc_q[cbgcs_pkg::SC_VOLT_BIT]; // R4
	assign card_3v_select     = legacy_mode && !sc_q[cbgcs_pkg::SC_VOLT_BIT]; // R4
	assign cb_stop_grant      = cb_stop_request && !sc_q[cbgcs_pkg::SC_KEEP_BIT]; // R5
	assign pci_stop_grant     = pci_stop_request && !sc_q[cbgcs_pkg::SC_KEEP_BIT]; // R5
	assign firewire_function_off = gc_q[cbgcs_pkg::GC_FW_OFF_BIT]; // R14

	wire [1:0] arb = gc_q[cbgcs_pkg::GC_ARB_LSB +: 2];
	// reserved encoding falls through to round robin
	assign arb_sel.fw_prio = (arb == cbgcs_pkg::CBGCS_ARB_FIREWIRE); // R15
	assign arb_sel.cb_prio = (arb == cbgcs_pkg::CBGCS_ARB_CARDBUS); // R15
	assign arb_sel.fair    = arb[1]; // R15

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serr_q <= 1'b0;
		end else begin
			serr_q <= cardbus_parity_error && sc_q[cbgcs_pkg::SC_PAR_BIT]; // R2
		end
	end
	assign serr_parity_pulse = serr_q;

	// ----------------------------------------------------------------
	// shared ring / pme terminal
	// ----------------------------------------------------------------
	wire mux_pme_only = sc_q[cbgcs_pkg::SC_MUX_BIT];
	always_comb begin
		if (mux_pme_only) begin
			pin_state = wake.pme_req ? cbgcs_pkg::CBGCS_PIN_PME : cbgcs_pkg::CBGCS_PIN_IDLE; // R7
		end else if (wake.ring_req) begin
			pin_state = cbgcs_pkg::CBGCS_PIN_RING; // R6
		end else if (wake.pme_req) begin
			pin_state = cbgcs_pkg::CBGCS_PIN_PME; // R6
		end else begin
			pin_state = cbgcs_pkg::CBGCS_PIN_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
		end else begin
			case (pin_state)
				cbgcs_pkg::CBGCS_PIN_RING: pin_q <= 1'b1;
				cbgcs_pkg::CBGCS_PIN_PME:  pin_q <= 1'b1;
				cbgcs_pkg::CBGCS_PIN_IDLE: pin_q <= 1'b0;
				default:                   pin_q <= 1'b0;
			endcase
		end
	end
	assign ring_pme_pin_n = !pin_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_wp_reset_value: assert property (@(posedge clk) disable iff (!rst_n) // R1
		$rose(rst_n) |-> !id_write_enable) else $error("write protect not set after reset");

	a_serr_gated: assert property (@(posedge clk) disable iff (!rst_n) // R2
		serr_parity_pulse |-> $past(cardbus_parity_error) && $past(sc_q[cbgcs_pkg::SC_PAR_BIT]))
		else $error("parity serr without enable");

	a_dma_needs_both: assert property (@(posedge clk) disable iff (!rst_n) // R3
		central_dma_active |-> terminals_central_dma && sc_q[cbgcs_pkg::SC_DMA_BIT])
		else $error("central dma active without enable");

	a_keep_blocks_stop: assert property (@(posedge clk) disable iff (!rst_n) // R5
		sc_q[cbgcs_pkg::SC_KEEP_BIT] |-> !cb_stop_grant && !pci_stop_grant)
		else $error("clock stop granted while keep set");

	a_ring_wins: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(!mux_pme_only && wake.ring_req) |=> !ring_pme_pin_n)
		else $error("ring output not driven on shared pin");

	a_pme_only: assert property (@(posedge clk) disable iff (!rst_n) // R7
		(mux_pme_only && !wake.pme_req) |=> ring_pme_pin_n)
		else $error("shared pin driven without pme in pme only mode");

	a_status_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // R8
		$past(cfg_req.rd && gs_hit) |-> cfg_rdata[15:11] == 5'h0_0)
		else $error("status reserved bits nonzero");

	a_ctrl_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // R9
		gc_q[7:4] == 4'h0 && !gc_q[2]) else $error("control reserved bits stored");

	a_err_set_wins: assert property (@(posedge clk) disable iff (!rst_n) // R11
		eeprom_error_pulse |=> err_q) else $error("data error not set");

	a_err_clear: assert property (@(posedge clk) disable iff (!rst_n) // R12
		(err_clear && !eeprom_error_pulse) |=> !err_q) else $error("data error not cleared");

	a_arb_fair: assert property (@(posedge clk) disable iff (!rst_n) // R15
		arb == 2'h3 |-> arb_sel.fair && !arb_sel.fw_prio && !arb_sel.cb_prio)
		else $error("reserved arbitration code not round robin");

	// the checks below restate the expression that drives each effect, so a
	// broken decode that feeds both sides would not show up
	a_sc_write: assert property (@(posedge clk) disable iff (!rst_n) // R16
		sc_wr |=> sc_q == $past(sc_wbyte[5:0] & cbgcs_pkg::SC_WR_MASK))
		else $error("system control write not stored");

	a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n) // R16
		gc_wr |=> gc_q == $past(gc_wbyte & cbgcs_pkg::GC_WR_MASK))
		else $error("control write not stored as masked");

	a_serr_follows: assert property (@(posedge clk) disable iff (!rst_n) // R2
		(cardbus_parity_error && sc_q[cbgcs_pkg::SC_PAR_BIT]) |=> serr_parity_pulse)
		else $error("enabled parity error not reported");

	a_volt_5v: assert property (@(posedge clk) disable iff (!rst_n) // R4
		(legacy_mode && sc_q[cbgcs_pkg::SC_VOLT_BIT]) |-> card_5v_select && !card_3v_select)
		else $error("5 V not requested");

	a_volt_3v: assert property (@(posedge clk) disable iff (!rst_n) // R4
		(legacy_mode && !sc_q[cbgcs_pkg::SC_VOLT_BIT]) |-> card_3v_select && !card_5v_select)
		else $error("3.3 V not requested");

	a_volt_off: assert property (@(posedge clk) disable iff (!rst_n) // R4
		!legacy_mode |-> !card_5v_select && !card_3v_select)
		else $error("voltage requested outside legacy mode");

	a_stop_free: assert property (@(posedge clk) disable iff (!rst_n) // R5
		!sc_q[cbgcs_pkg::SC_KEEP_BIT] |-> cb_stop_grant == cb_stop_request
			&& pci_stop_grant == pci_stop_request)
		else $error("clock stop refused while keep clear");

	a_pme_shared: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(!mux_pme_only && wake.pme_req) |=> !ring_pme_pin_n)
		else $error("pme not driven on shared pin");

	a_pin_idle: assert property (@(posedge clk) disable iff (!rst_n) // R6
		(!wake.ring_req && !wake.pme_req) |=> ring_pme_pin_n)
		else $error("shared pin driven with no request");

	a_pme_routed: assert property (@(posedge clk) disable iff (!rst_n) // R7
		(mux_pme_only && wake.pme_req) |=> !ring_pme_pin_n)
		else $error("pme not driven in pme only mode");

	// present is only captured while reset is low
	a_present_frozen: assert property (@(posedge clk) disable iff (!rst_n) // R10
		$past(rst_n) |-> $stable(present_q))
		else $error("eeprom present changed outside reset");

	a_err_hold: assert property (@(posedge clk) disable iff (!rst_n) // R12
		(!eeprom_error_pulse && !err_clear) |=> $stable(err_q))
		else $error("data error changed without cause");

	a_busy_live: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(cfg_req.rd && gs_hit) |=> cfg_rdata[8] == $past(eeprom_loading))
		else $error("busy bit does not follow loader");

	a_fw_off_write: assert property (@(posedge clk) disable iff (!rst_n) // R14
		gc_wr |=> firewire_function_off == $past(gc_wbyte[cbgcs_pkg::GC_FW_OFF_BIT]))
		else $error("function off does not follow write");

	a_arb_firewire: assert property (@(posedge clk) disable iff (!rst_n) // R15
		arb == cbgcs_pkg::CBGCS_ARB_FIREWIRE |-> arb_sel.fw_prio && !arb_sel.cb_prio
			&& !arb_sel.fair)
		else $error("firewire priority not selected");

	a_arb_cardbus: assert property (@(posedge clk) disable iff (!rst_n) // R15
		arb == cbgcs_pkg::CBGCS_ARB_CARDBUS |-> arb_sel.cb_prio && !arb_sel.fw_prio
			&& !arb_sel.fair)
		else $error("cardbus priority not selected");

	a_arb_round: assert property (@(posedge clk) disable iff (!rst_n) // R15
		arb == cbgcs_pkg::CBGCS_ARB_FAIR |-> arb_sel.fair && !arb_sel.fw_prio
			&& !arb_sel.cb_prio)
		else $error("round robin not selected");

endmodule

/* logic/cbgcs_sync3.sv */
/*
 * three-stage synchroniser for a pin input, with agreement qualification.
 * assumes a single clock; the output changes only when stages two and
 * three agree.
 */
`timescale 1ns/1ps
module cbgcs_sync3 (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic dout_q;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
			dout_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				dout_q <= s3_q;
			end
		end
	end

	assign dout = dout_q;
endmodule

/* verification/tb_card_bridge_general_control_status.sv */
/*
 * self-checking bench for the general control and status register bank.
 * assumes cbgcs_pkg and cbgcs_regs are compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
module tb_card_bridge_general_control_status;
	logic                      clk, rst_n, scl_pin, err_p, loading, par_err;
	logic                      term_dma, legacy, cb_req, pci_req, hit, id_we, serr;
	logic                      dma_act, v5, v3, cb_gnt, pci_gnt, pin_n, fw_off, h;
	logic [31:0]               rdata, d;
	cbgcs_pkg::cbgcs_cfg_req_t req;
	cbgcs_pkg::cbgcs_wake_t    wake;
	cbgcs_pkg::cbgcs_arb_sel_t arb_sel;
	int                        n_errors, n_checks;

	cbgcs_regs uut (.clk(clk), .rst_n(rst_n), .cfg_req(req), .cfg_rdata(rdata),
		.cfg_hit(hit), .scl_pin(scl_pin), .eeprom_error_pulse(err_p),
		.eeprom_loading(loading), .cardbus_parity_error(par_err),
		.terminals_central_dma(term_dma), .legacy_mode(legacy),
		.cb_stop_request(cb_req), .pci_stop_request(pci_req), .wake(wake),
		.id_write_enable(id_we), .serr_parity_pulse(serr),
		.central_dma_active(dma_act), .card_5v_select(v5), .card_3v_select(v3),
		.cb_stop_grant(cb_gnt), .pci_stop_grant(pci_gnt), .ring_pme_pin_n(pin_n),
		.firewire_function_off(fw_off), .arb_sel(arb_sel));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: wd};
		@(posedge clk);
		req <= '0;
	endtask

	// hit is combinational, so it is sampled while the request is up
	task automatic rd(input logic [7:0] a, output logic [31:0] rd_d, output logic rd_h);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0000_0000};
		#1 rd_h = hit;
		@(posedge clk);
		req <= '0;
		#1 rd_d = rdata;
	endtask

	task automatic do_reset(input logic scl);
		@(posedge clk);
		rst_n <= 1'b0;
		scl_pin <= scl;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic pin_case(input logic ring, input logic pme, input logic exp);
		@(posedge clk);
		wake <= '{ring_req: ring, pme_req: pme};
		repeat (2) @(posedge clk);
		#1 chk(pin_n, exp, "shared pin");
	endtask

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		scl_pin = 1'b1;
		err_p = 1'b0;
		loading = 1'b0;
		par_err = 1'b0;
		term_dma = 1'b1;
		legacy = 1'b1;
		cb_req = 1'b1;
		pci_req = 1'b1;
		req = '0;
		wake = '0;
		n_errors = 0;
		n_checks = 0;
		do_reset(1'b1);
		rd(8'h80, d, h);
		chk(d[5:0], cbgcs_pkg::SC_RESET, "sysctl reset");
		chk(id_we, 1'b0, "id write enable");
		chk(h, 1'b1, "sysctl hit");
		rd(8'h84, d, h);
		chk(h, 1'b1, "status hit");
		chk(d[15:8], 8'h04, "status reset");
		chk(d[23:16], 8'h00, "control reset");
		chk({d[31:24], d[7:0]}, 16'h0000, "unused lanes");
		$display("test reset done");
		// every sysctl setting, with all qualifying inputs active
		for (int v = 0; v < 64; v++) begin
			wr(8'h80, 4'h1, {24'h00_0000, 2'b11, v[5:0]});
			rd(8'h80, d, h);
			chk(d[5:0], v[5:0], "sysctl readback");
			chk(id_we, !v[5], "id write enable");
			chk(dma_act, v[3], "central dma");
			chk({v5, v3}, {v[2], !v[2]}, "card voltage");
			chk({cb_gnt, pci_gnt}, {2{!v[1]}}, "clock stop");
			@(posedge clk);
			par_err <= 1'b1;
			@(posedge clk);
			par_err <= 1'b0;
			#1 chk(serr, v[4], "parity serr");
			@(posedge clk);
			#1 chk(serr, 1'b0, "parity serr end");
			pin_case(1'b1, 1'b0, v[0]);
			pin_case(1'b1, 1'b1, 1'b0);
			pin_case(1'b0, 1'b1, 1'b0);
			pin_case(1'b0, 1'b0, 1'b1);
		end
		@(posedge clk);
		legacy <= 1'b0;
		term_dma <= 1'b0;
		@(posedge clk);
		#1 chk({v5, v3}, 2'b00, "voltage outside legacy");
		chk(dma_act, 1'b0, "dma without terminals");
		$display("test system control done");
		@(posedge clk);
		err_p <= 1'b1;
		@(posedge clk);
		err_p <= 1'b0;
		rd(8'h84, d, h);
		chk(d[15:8], 8'h06, "error set");
		wr(8'h85, 4'h2, 32'h0000_fd00);
		rd(8'h84, d, h);
		chk(d[15:8], 8'h06, "write zero keeps error");
		wr(8'h85, 4'h2, 32'h0000_0200);
		rd(8'h84, d, h);
		chk(d[15:8], 8'h04, "write one clears");
		@(posedge clk);
		loading <= 1'b1;
		rd(8'h84, d, h);
		chk(d[15:8], 8'h05, "busy");
		@(posedge clk);
		loading <= 1'b0;
		rd(8'h84, d, h);
		chk(d[15:8], 8'h04, "idle");
		$display("test status done");
		wr(8'h86, 4'h4, 32'h00ff_0000);
		rd(8'h84, d, h);
		chk(d[23:16], 8'h0b, "control mask");
		chk(fw_off, 1'b1, "function off");
		for (int a = 0; a < 4; a++) begin
			wr(8'h86, 4'h4, {8'h00, 6'h00, a[1:0], 16'h0000});
			rd(8'h84, d, h);
			chk(d[23:16], {6'h00, a[1:0]}, "arb readback");
			chk(fw_off, 1'b0, "function on");
			chk(arb_sel, (a == 0) ? 3'b100 : (a == 1) ? 3'b010 : 3'b001, "arb select");
		end
		rd(8'h90, d, h);
		chk(d, 32'h0000_0000, "unmapped data");
		chk(h, 1'b0, "unmapped hit");
		$display("test control done");
		// second reset with the eeprom clock line low
		do_reset(1'b0);
		rd(8'h84, d, h);
		chk(d[15:8], 8'h00, "no eeprom");
		chk(d[23:16], 8'h00, "control reset again");
		rd(8'h80, d, h);
		chk(d[5:0], cbgcs_pkg::SC_RESET, "sysctl reset again");
		$display("test second reset done");
		results();
	end
endmodule
